// ### hdl/reset_extender.sv
// Purpose: one reset stretcher that releases a fixed number of tick strobes after its input falls, or at once if that input rose and fell while ce was low
// Assumes: tick is a one-cycle strobe on mclk marking a falling edge of the pacing clock
// Notes: the output asserts in the same cycle as hold, with no clock needed
module reset_extender #(
  parameter int unsigned TICKS = 32,
  parameter int unsigned CNT_W = 8
) (
  // clock and control
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // pacing and input reset
  input wire logic tick,
  input wire logic hold,
  // stretched reset
  output logic rst_out
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [CNT_W-1:0] LOAD = CNT_W'(TICKS);
  localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

  if (TICKS < 1 || TICKS >= (1 << CNT_W)) begin : bad_ticks
    $error("reset_extender: TICKS does not fit the counter");
  end

  logic busy_q;
  logic [CNT_W-1:0] cnt_q;
  wire last_tick = busy_q & tick & (cnt_q == ONE);

  // reload while the input reset stands, count only once it is gone
  always_ff @(posedge mclk) begin
    if (rst) begin
      busy_q <= 1'b1;
      cnt_q <= LOAD;
    end else if (ce) begin
      if (hold) begin
        busy_q <= 1'b1;
        cnt_q <= LOAD;
      end else if (busy_q && tick) begin
        busy_q <= ~last_tick; // release lands on a tick, i.e. a falling edge
        cnt_q <= cnt_q - ONE;
      end
    end
  end

  // input reset passes straight through so assertion never waits for a clock
  assign rst_out = hold | busy_q;

  default clocking dc @(posedge mclk); endclocking
  default disable iff (rst);

  hold_forces_out_a: assert property (hold |-> rst_out)
    else $error("stretched reset dropped while its input reset stands");
  reload_on_hold_a: assert property (hold && ce |=> busy_q && cnt_q == LOAD)
    else $error("counter not reloaded by its input reset");
  release_on_tick_a: assert property ($fell(busy_q) |-> $past(tick) && $past(ce))
    else $error("stretched reset released off a falling-edge strobe");
  count_freeze_a: assert property (!ce |=> $stable(busy_q) && $stable(cnt_q))
    else $error("stretch counter moved while the clock enable was low");

endmodule // reset_extender

// ### hdl/rst_seq_defines.svh
// Purpose: shared offsets-free constants for the staged reset release sequencer
// Assumes: counts are in ticks of the clock that paces each stage
// Notes: definitions only
`ifndef RST_SEQ_DEFINES_SVH
`define RST_SEQ_DEFINES_SVH

// power-on stretch, in oscillator clock falling edges
`define POR_EXT_TICKS 64
// hold on the software and watchdog request logic, in oscillator edges
`define SYNC_GEN_TICKS 3
// clock-generation stretch after the combined reset, in oscillator edges
`define CLKGEN_EXT_TICKS 32
// peripheral stretch after clock generation starts, in system clock edges
`define PERIP_EXT_TICKS 32
// core stretch after the peripherals start, in system clock edges
`define CORE_EXT_TICKS 32
// width of every stretch counter
`define EXT_CNT_W 8

`endif

// ### hdl/rst_seq_pkg.sv
// Purpose: types shared by the reset sequencer files
// Assumes: nothing
// Notes: phase order follows the release order
package rst_seq_pkg;
  timeunit 1ns;
  timeprecision 100ps;

  // which reset stage is still holding the device
  typedef enum logic [2:0] {
    PH_POR,
    PH_COMBINED,
    PH_CLKGEN,
    PH_PERIP,
    PH_CORE,
    PH_RUN
  } seq_phase_t;

  // cause of the most recent combined reset: {software, watchdog, external, power-on}
  typedef logic [3:0] reset_cause_t;

endpackage

// ### hdl/staged_reset_release_sequencer.sv
// Purpose: combine five reset sources and release clock generation, peripherals and core in order
// Assumes: mclk runs at 40 MHz; osc_fall_tick and sys_fall_tick are one-cycle strobes on mclk
//   marking falling edges of the oscillator clock and the delayed system clock
// Notes: resets assert at once from the asynchronous sources and one mclk cycle after a synchronous one; the stretched resets release
//   only on a strobe, except when their input reset rose and fell while ce was low
// Contract
// - five sources: two asynchronous, three synchronous
// - control register write creates software reset
// - test access port reset by power-on only
// - power-on reset stretched 64 oscillator cycles
// - combined reset ORs sources, holds everything
// - combined release enables control, sync, clkgen
// - sync logic released three oscillator cycles later
// - clock-generation reset released 32 oscillator cycles later
// - early counters paced by the oscillator clock
// - clock-generation stretch totals up to 96 cycles
// - clock-generation release on oscillator falling edge
// - clkgen release starts clocks and peripheral extender
// - peripheral reset released 32 system cycles later
// - core reset released 32 system cycles later
// - peripheral and core release on falling edge
// - core release lets the core run
// - no interrupt requests are raised
`include "rst_seq_defines.svh"

module staged_reset_release_sequencer #(
  parameter int unsigned POR_TICKS = `POR_EXT_TICKS,
  parameter int unsigned SYNC_TICKS = `SYNC_GEN_TICKS,
  parameter int unsigned CLKGEN_TICKS = `CLKGEN_EXT_TICKS,
  parameter int unsigned PERIP_TICKS = `PERIP_EXT_TICKS,
  parameter int unsigned CORE_TICKS = `CORE_EXT_TICKS,
  parameter int unsigned CNT_W = `EXT_CNT_W
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // pacing strobes
  input wire logic osc_fall_tick,
  input wire logic sys_fall_tick,
  // asynchronous sources
  input wire logic por_raw,
  input wire logic ext_reset,
  // synchronous sources
  input wire logic sw_reset_write,
  input wire logic watchdog_timeout_reset,
  input wire logic watchdog_clock_loss_reset,
  // resets out
  output logic tap_reset,
  output logic extended_por_reset,
  output logic combined_reset,
  output logic sync_logic_reset,
  output logic clock_generation_reset,
  output logic peripheral_reset,
  output logic core_reset,
  // enables and status
  output logic ctrl_enable,
  output logic clock_gen_enable,
  output logic core_run,
  output rst_seq_pkg::seq_phase_t phase,
  output rst_seq_pkg::reset_cause_t reset_cause,
  output logic intr_req
);
  timeunit 1ns;
  timeprecision 100ps;
  import rst_seq_pkg::*;

  if (POR_TICKS >= (1 << CNT_W) || CLKGEN_TICKS >= (1 << CNT_W) || PERIP_TICKS >= (1 << CNT_W)
      || CORE_TICKS >= (1 << CNT_W) || SYNC_TICKS >= CLKGEN_TICKS
      || POR_TICKS + CLKGEN_TICKS >= (1 << CNT_W)) begin : bad_counts
    $error("staged_reset_release_sequencer: counts do not fit or sync outlasts clkgen");
  end

  logic sw_req_q;
  logic wd_req_q;
  logic comb_q;
  seq_phase_t phase_q;
  reset_cause_t cause_q;

  // power-on stretch, paced by the oscillator since no system clock runs yet
  reset_extender #(.TICKS(POR_TICKS), .CNT_W(CNT_W)) u_por_ext (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .tick(osc_fall_tick),
    .hold(por_raw),
    .rst_out(extended_por_reset)
  );

  // combined reset: asynchronous sources pass straight through, synchronous ones are latched
  assign combined_reset = extended_por_reset | ext_reset | sw_req_q | wd_req_q;
  // the test access port sees the power-on reset alone
  assign tap_reset = por_raw;

  // hold on the software and watchdog request logic
  reset_extender #(.TICKS(SYNC_TICKS), .CNT_W(CNT_W)) u_sync_gen (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .tick(osc_fall_tick),
    .hold(combined_reset),
    .rst_out(sync_logic_reset)
  );

  // clock-generation stretch; with the power-on stretch in front it totals up to 96 cycles
  reset_extender #(.TICKS(CLKGEN_TICKS), .CNT_W(CNT_W)) u_clkgen_ext (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .tick(osc_fall_tick),
    .hold(combined_reset),
    .rst_out(clock_generation_reset)
  );

  // peripheral stretch runs only once clock generation is out of reset
  reset_extender #(.TICKS(PERIP_TICKS), .CNT_W(CNT_W)) u_perip_ext (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .tick(sys_fall_tick),
    .hold(clock_generation_reset),
    .rst_out(peripheral_reset)
  );

  // core stretch gives peripherals such as the flash interface set-up time
  reset_extender #(.TICKS(CORE_TICKS), .CNT_W(CNT_W)) u_core_ext (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .tick(sys_fall_tick),
    .hold(peripheral_reset),
    .rst_out(core_reset)
  );

  // enables that follow the releases
  assign ctrl_enable = ~combined_reset;
  assign clock_gen_enable = ~clock_generation_reset;
  assign core_run = ~core_reset;
  // this block never asks for an interrupt
  assign intr_req = 1'b0;

  // synchronous request capture; gated by the sync hold so a source cannot re-trigger
  // itself before its own logic has had a reset of reasonable length
  wire sw_take = sw_reset_write & ctrl_enable & ~sync_logic_reset;
  wire wd_take = (watchdog_timeout_reset | watchdog_clock_loss_reset) & ~sync_logic_reset;

  // request flops clear while the sync hold stands, which ends the combined reset they raised
  always_ff @(posedge mclk) begin
    if (rst) begin
      sw_req_q <= 1'b0;
      wd_req_q <= 1'b0;
    end else if (ce) begin
      sw_req_q <= sw_take | (sw_req_q & ~sync_logic_reset);
      wd_req_q <= wd_take | (wd_req_q & ~sync_logic_reset);
    end
  end

  // phase decode, earliest holding stage wins
  wire seq_phase_t phase_d = extended_por_reset ? PH_POR :
                             combined_reset ? PH_COMBINED :
                             clock_generation_reset ? PH_CLKGEN :
                             peripheral_reset ? PH_PERIP :
                             core_reset ? PH_CORE : PH_RUN;
  wire comb_rise = combined_reset & ~comb_q;
  // the take terms are zero at a rise, since a standing combined reset also holds the sync hold
  wire reset_cause_t cause_d = {sw_req_q | sw_take, wd_req_q | wd_take, ext_reset, extended_por_reset};

  // status flops: phase and the cause captured at each new combined reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      phase_q <= PH_POR;
      cause_q <= 4'h1;
      comb_q <= 1'b1;
    end else if (ce) begin
      phase_q <= phase_d;
      comb_q <= combined_reset;
      if (comb_rise) begin
        cause_q <= cause_d;
      end
    end
  end

  assign phase = phase_q;
  assign reset_cause = cause_q;

  // ---- checking helpers: strobe counts since each release cause ----
  logic [CNT_W-1:0] osc_since_por_q;
  logic [CNT_W-1:0] osc_since_comb_q;
  logic [CNT_W-1:0] sys_since_clkgen_q;
  logic [CNT_W-1:0] sys_since_perip_q;
  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [CNT_W-1:0] POR_N = CNT_W'(POR_TICKS);
  localparam logic [CNT_W-1:0] SYNC_N = CNT_W'(SYNC_TICKS);
  localparam logic [CNT_W-1:0] CLKGEN_N = CNT_W'(CLKGEN_TICKS);
  localparam logic [CNT_W-1:0] PERIP_N = CNT_W'(PERIP_TICKS);
  localparam logic [CNT_W-1:0] CORE_N = CNT_W'(CORE_TICKS);
  localparam logic [CNT_W-1:0] TOTAL_N = CNT_W'(POR_TICKS + CLKGEN_TICKS);

  // saturating counters, cleared while their own input reset stands
  always_ff @(posedge mclk) begin
    if (rst) begin
      osc_since_por_q <= '0;
      osc_since_comb_q <= '0;
      sys_since_clkgen_q <= '0;
      sys_since_perip_q <= '0;
    end else if (ce) begin
      if (por_raw) begin
        osc_since_por_q <= '0;
      end else if (osc_fall_tick && osc_since_por_q != CNT_MAX) begin
        osc_since_por_q <= osc_since_por_q + CNT_ONE;
      end
      if (combined_reset) begin
        osc_since_comb_q <= '0;
      end else if (osc_fall_tick && osc_since_comb_q != CNT_MAX) begin
        osc_since_comb_q <= osc_since_comb_q + CNT_ONE;
      end
      if (clock_generation_reset) begin
        sys_since_clkgen_q <= '0;
      end else if (sys_fall_tick && sys_since_clkgen_q != CNT_MAX) begin
        sys_since_clkgen_q <= sys_since_clkgen_q + CNT_ONE;
      end
      if (peripheral_reset) begin
        sys_since_perip_q <= '0;
      end else if (sys_fall_tick && sys_since_perip_q != CNT_MAX) begin
        sys_since_perip_q <= sys_since_perip_q + CNT_ONE;
      end
    end
  end

  default clocking dc @(posedge mclk); endclocking
  default disable iff (rst);

  // sources and holds: every stage follows its input reset with no clock in between
  por_holds_all_a: assert property (por_raw |-> extended_por_reset && combined_reset
                                    && clock_generation_reset && peripheral_reset && core_reset)
    else $error("power-on reset did not hold every stage");
  ext_holds_all_a: assert property (ext_reset |-> combined_reset && sync_logic_reset
                                    && clock_generation_reset && peripheral_reset && core_reset)
    else $error("external reset did not hold every stage at once");
  tap_por_only_a: assert property (!por_raw |-> !tap_reset)
    else $error("test access port reset by a source other than power-on");
  tap_follow_a: assert property (por_raw |-> tap_reset)
    else $error("test access port missed the power-on reset");
  comb_holds_a: assert property (combined_reset |-> sync_logic_reset && clock_generation_reset)
    else $error("combined reset did not hold the sync and clock-generation stages");
  sync_first_a: assert property (!clock_generation_reset |-> !sync_logic_reset)
    else $error("sync hold outlasted the clock-generation reset");
  ctrl_gate_a: assert property (combined_reset |-> !ctrl_enable && !clock_gen_enable && !core_run)
    else $error("enable raised while the combined reset stands");
  release_order_a: assert property ((!core_reset |-> !peripheral_reset)
                                    and (!peripheral_reset |-> !clock_generation_reset))
    else $error("a later stage released before an earlier one");

  // release counts; a pass-through pulse while ce is low never reloads a counter,
  // so a fall whose input reset stood one edge earlier is not a counter release
  por_stretch_a: assert property ($fell(extended_por_reset) && !$past(por_raw)
                                  |-> osc_since_por_q == POR_N)
    else $error("extended power-on reset released after the wrong count");
  sync_release_a: assert property ($fell(sync_logic_reset) && !$past(combined_reset)
                                   |-> osc_since_comb_q == SYNC_N)
    else $error("sync reset released after the wrong oscillator count");
  clkgen_release_a: assert property ($fell(clock_generation_reset) && !$past(combined_reset)
                                     |-> osc_since_comb_q == CLKGEN_N && $past(osc_fall_tick))
    else $error("clock-generation reset released at the wrong oscillator edge");
  // every clock-generation release has seen the full power-on stretch plus the clock-generation stretch since power-on
  clkgen_total_a: assert property ($fell(clock_generation_reset) && !$past(combined_reset)
                                   |-> osc_since_por_q >= TOTAL_N)
    else $error("clock-generation stretch shorter than its power-on total");
  perip_release_a: assert property ($fell(peripheral_reset) && !$past(clock_generation_reset)
                                    |-> sys_since_clkgen_q == PERIP_N && $past(sys_fall_tick))
    else $error("peripheral reset released at the wrong system edge");
  core_release_a: assert property ($fell(core_reset) && !$past(peripheral_reset)
                                   |-> sys_since_perip_q == CORE_N && $past(sys_fall_tick))
    else $error("core reset released at the wrong system edge");

  // software and watchdog requests: taken only outside the sync hold, cleared by it
  sw_write_a: assert property (sw_reset_write && ce && !sync_logic_reset |=> combined_reset)
    else $error("control register write did not raise the software reset");
  wd_source_a: assert property ((watchdog_timeout_reset || watchdog_clock_loss_reset) && ce
                                && !sync_logic_reset |=> combined_reset && clock_generation_reset)
    else $error("watchdog source did not raise the combined reset");
  sw_refused_a: assert property (sync_logic_reset && !sw_req_q |=> !sw_req_q)
    else $error("software request taken during the sync hold");
  wd_refused_a: assert property (sync_logic_reset && !wd_req_q |=> !wd_req_q)
    else $error("watchdog request taken during the sync hold");
  req_clear_a: assert property ((sw_req_q || wd_req_q) && ce |=> !sw_req_q && !wd_req_q)
    else $error("synchronous request outlived its sync hold");

  // status registers; phase lags the stages by one cycle
  cause_capture_a: assert property (comb_rise && ce |=> reset_cause == $past(cause_d))
    else $error("reset cause not captured at the combined reset");
  sw_cause_a: assert property (sw_req_q && !comb_q && ce |=> reset_cause[3])
    else $error("software reset not recorded as a cause");
  ext_cause_a: assert property (ext_reset && !comb_q && ce |=> reset_cause[1])
    else $error("external reset not recorded as a cause");
  por_cause_a: assert property (por_raw && !comb_q && ce |=> reset_cause[0])
    else $error("power-on reset not recorded as a cause");
  phase_follow_a: assert property (ce |=> phase == $past(phase_d))
    else $error("phase does not follow the earliest holding stage");
  status_freeze_a: assert property (!ce |=> $stable(phase) && $stable(reset_cause))
    else $error("status moved while the clock enable was low");
  no_irq_a: assert property (!intr_req)
    else $error("interrupt request raised");

endmodule // staged_reset_release_sequencer

// ### tb/reset_far_side_model.sv
// Purpose: far side of the reset sequencer, giving oscillator and system clock edges as strobes
// Assumes: mclk is the fast sampling clock; slow widens the gap between strobes
// Notes: the system clock stands still until clock generation is enabled
module reset_far_side_model (
  // sampling clock and pacing choice
  input wire logic mclk,
  input wire logic slow,
  // start of clock generation
  input wire logic clock_gen_enable,
  // falling-edge strobes
  output logic osc_fall_tick,
  output logic sys_fall_tick
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] osc_q = 3'h0;
  logic [2:0] sys_q = 3'h0;
  wire logic [2:0] gap = slow ? 3'h4 : 3'h0; // prompt is every cycle, slow every fifth

  initial begin
    osc_fall_tick = 1'b0;
    sys_fall_tick = 1'b0;
  end

  // oscillator edges run from power-up, since nothing else is clocked that early
  always @(negedge mclk) begin
    osc_q <= (osc_q >= gap) ? 3'h0 : osc_q + 3'h1;
    osc_fall_tick <= (osc_q >= gap);
  end

  // system clock edges appear only once the clock generator leaves reset
  always @(negedge mclk) begin
    sys_q <= (!clock_gen_enable || sys_q >= gap) ? 3'h0 : sys_q + 3'h1;
    sys_fall_tick <= clock_gen_enable && (sys_q >= gap);
  end
endmodule // reset_far_side_model

// ### tb/tb_top.sv
// Purpose: self-checking bench for the staged reset release sequencer
// Assumes: short stretch counts; strobes come from the far-side model
// Notes: a cycle model steps at each falling edge and is compared with every reset output
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import rst_seq_pkg::*;
  localparam int unsigned NP = 4, NS = 2, NC = 3, NE = 3, NK = 3;
  logic mclk = 1'b0;
  logic rst, ce, por_raw, ext_reset, sw_reset_write, watchdog_timeout_reset, watchdog_clock_loss_reset, slow;
  logic osc_fall_tick, sys_fall_tick, tap_reset, extended_por_reset, combined_reset, sync_logic_reset;
  logic clock_generation_reset, peripheral_reset, core_reset, ctrl_enable, clock_gen_enable, core_run, intr_req;
  seq_phase_t phase;
  reset_cause_t reset_cause;
  int error_cnt = 0, checked = 0, seed;
  int unsigned c_po, c_sy, c_cg, c_pe, c_co;
  logic sw_q, wd_q, m_ep, m_cb, m_sy, m_cg, m_pe, m_co, m_cq;
  seq_phase_t m_ph;
  reset_cause_t m_cause;

  // 40 MHz clock
  always #12.5 mclk = ~mclk;

  staged_reset_release_sequencer #(.POR_TICKS(NP), .SYNC_TICKS(NS), .CLKGEN_TICKS(NC), .PERIP_TICKS(NE),
    .CORE_TICKS(NK), .CNT_W(8)) u_staged_reset_release_sequencer (.mclk, .rst, .ce, .osc_fall_tick,
    .sys_fall_tick, .por_raw, .ext_reset, .sw_reset_write, .watchdog_timeout_reset,
    .watchdog_clock_loss_reset, .tap_reset, .extended_por_reset, .combined_reset, .sync_logic_reset,
    .clock_generation_reset, .peripheral_reset, .core_reset, .ctrl_enable, .clock_gen_enable, .core_run,
    .phase, .reset_cause, .intr_req);

  reset_far_side_model u_reset_far_side_model (.mclk, .slow, .clock_gen_enable, .osc_fall_tick,
    .sys_fall_tick);

  task automatic chk(input string name, input logic seen, input logic exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %b seen %b", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // model levels that follow the sources with no clock in between
  task automatic mcomb();
    m_ep = por_raw | (c_po != 0);
    m_cb = m_ep | ext_reset | sw_q | wd_q;
    m_sy = m_cb | (c_sy != 0);
    m_cg = m_cb | (c_cg != 0);
    m_pe = m_cg | (c_pe != 0);
    m_co = m_pe | (c_co != 0);
  endtask

  // a stretch reloads while its input holds and counts down one per strobe
  function automatic int unsigned nxt(int unsigned c, logic h, logic t, int unsigned n);
    return h ? n : ((t && c != 0) ? c - 1 : c);
  endfunction

  // one mclk cycle: step the model over the rising edge just past, then compare
  task automatic cyc();
    @(negedge mclk);
    mcomb();
    if (rst) begin
      {c_po, c_sy, c_cg, c_pe, c_co} = {NP, NS, NC, NE, NK};
      {sw_q, wd_q} = 2'h0;
      m_ph = PH_POR;
      m_cause = 4'h1;
      m_cq = 1'b1;
    end else if (ce) begin
      // earliest stage still holding, and the sources seen at each new combined reset
      m_ph = m_ep ? PH_POR : m_cb ? PH_COMBINED : m_cg ? PH_CLKGEN :
             m_pe ? PH_PERIP : m_co ? PH_CORE : PH_RUN;
      if (m_cb && !m_cq) begin
        m_cause = {sw_q, wd_q, ext_reset, m_ep};
      end
      m_cq = m_cb;
      c_po = nxt(c_po, por_raw, osc_fall_tick, NP);
      c_sy = nxt(c_sy, m_cb, osc_fall_tick, NS);
      c_cg = nxt(c_cg, m_cb, osc_fall_tick, NC);
      c_pe = nxt(c_pe, m_cg, sys_fall_tick, NE);
      c_co = nxt(c_co, m_pe, sys_fall_tick, NK);
      sw_q = !m_sy && (sw_reset_write || sw_q);
      wd_q = !m_sy && (watchdog_timeout_reset || watchdog_clock_loss_reset || wd_q);
    end
    mcomb();
    chk("tap_reset", tap_reset, por_raw);
    chk("extended_por_reset", extended_por_reset, m_ep);
    chk("combined_reset", combined_reset, m_cb);
    chk("ctrl_enable", ctrl_enable, !m_cb);
    chk("sync_logic_reset", sync_logic_reset, m_sy);
    chk("clock_generation_reset", clock_generation_reset, m_cg);
    chk("clock_gen_enable", clock_gen_enable, !m_cg);
    chk("peripheral_reset", peripheral_reset, m_pe);
    chk("core_reset", core_reset, m_co);
    chk("core_run", core_run, !m_co);
    chk("intr_req", intr_req, 1'b0);
    chk("phase", phase === m_ph, 1'b1);
    chk("reset_cause", reset_cause === m_cause, 1'b1);
  endtask

  // bounded wait on a release; running out ends the run
  task automatic wait_hi(input bit on_core, input int lim);
    for (int k = 0; k < lim; k++) begin
      if ((on_core ? core_run : clock_gen_enable) === 1'b1) return;
      cyc();
    end
    chk("release_wait", 1'b0, 1'b1);
    give_verdict();
  endtask

  initial begin
    seed = 77;
    {rst, ce, por_raw, slow} = 4'hf;
    {ext_reset, sw_reset_write, watchdog_timeout_reset, watchdog_clock_loss_reset} = 4'h0;
    repeat (16) cyc();
    rst = 1'b0;
    slow = 1'b0;
    // power-on release through every stage with prompt strobes
    por_raw = 1'b0;
    wait_hi(1'b1, 200);
    $display("test power_on done");
    // accepted write, then a second write inside the sync hold that must be dropped
    sw_reset_write = 1'b1;
    cyc();
    cyc();
    sw_reset_write = 1'b0;
    wait_hi(1'b1, 200);
    $display("test software_reset done");
    // timeout as a pulse, clock loss as a level that outlives the sync hold
    watchdog_timeout_reset = 1'b1;
    cyc();
    watchdog_timeout_reset = 1'b0;
    wait_hi(1'b1, 200);
    watchdog_clock_loss_reset = 1'b1;
    repeat (6) cyc();
    watchdog_clock_loss_reset = 1'b0;
    wait_hi(1'b1, 200);
    $display("test watchdog done");
    // external reset reasserted while the peripheral stretch is counting
    ext_reset = 1'b1;
    cyc();
    ext_reset = 1'b0;
    wait_hi(1'b0, 200);
    ext_reset = 1'b1;
    repeat (2) cyc();
    ext_reset = 1'b0;
    wait_hi(1'b1, 200);
    $display("test abort done");
    // power glitch with slow strobes, then a second reset mid-sequence
    slow = 1'b1;
    por_raw = 1'b1;
    cyc();
    por_raw = 1'b0;
    wait_hi(1'b0, 400);
    rst = 1'b1;
    repeat (2) cyc();
    rst = 1'b0;
    wait_hi(1'b1, 800);
    $display("test slow_power_glitch done");
    // random sources, stalls and pacing
    repeat (1500) begin
      ce = ($random(seed) & 7) != 0;
      slow = ($random(seed) & 1) != 0;
      ext_reset = ($random(seed) & 63) == 0;
      sw_reset_write = ($random(seed) & 31) == 0;
      watchdog_timeout_reset = ($random(seed) & 63) == 0;
      watchdog_clock_loss_reset = ($random(seed) & 63) == 0;
      por_raw = ($random(seed) & 255) == 0;
      cyc();
    end
    {ce, slow, por_raw, ext_reset, sw_reset_write, watchdog_timeout_reset, watchdog_clock_loss_reset} = 7'h40;
    wait_hi(1'b1, 1000);
    cyc();
    chk("phase_run", phase === PH_RUN, 1'b1);
    $display("test random done");
    give_verdict();
  end
endmodule // tb_top
